//--- src/gpio_bank_pkg.sv
// constants, types and register decode for the six-port parallel i/o bank
// assumes a single clock domain and a 32-bit axi4-lite register bus
package gpio_bank_pkg;

    localparam int NUM_PORTS = 6;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;

    // port numbering
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;

    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bytes_t;
    typedef logic [NUM_PORTS-1:0] port_flags_t;

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_PORT_A_DATA = 6'h00;
    localparam logic [5:0] IDX_PORT_A_DIRECTION = 6'h01;
    localparam logic [5:0] IDX_PORT_A_OPTION = 6'h02;
    localparam logic [5:0] IDX_PORT_B_DATA = 6'h03;
    localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] IDX_PORT_C_DATA = 6'h06;
    localparam logic [5:0] IDX_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] IDX_PORT_C_OPTION = 6'h08;
    localparam logic [5:0] IDX_PORT_D_DATA = 6'h09;
    localparam logic [5:0] IDX_PORT_D_DIRECTION = 6'h0a;
    localparam logic [5:0] IDX_PORT_D_OPTION = 6'h0b;
    localparam logic [5:0] IDX_PORT_E_DATA = 6'h0c;
    localparam logic [5:0] IDX_PORT_E_DIRECTION = 6'h0d;
    localparam logic [5:0] IDX_PORT_E_OPTION = 6'h0e;
    localparam logic [5:0] IDX_PORT_F_DATA = 6'h0f;
    localparam logic [5:0] IDX_PORT_F_DIRECTION = 6'h10;

    // reset values
    localparam logic [PORT_W-1:0] RESET_DATA = 8'h00;
    localparam logic [PORT_W-1:0] RESET_DIRECTION = 8'h00;
    localparam logic [PORT_W-1:0] RESET_OPTION = 8'h00;

    // fixed pad features per port, index = port number
    localparam port_flags_t HAS_OPTION_PORTS = 6'h1d;
    localparam port_flags_t IRQ_PORTS = 6'h0d;
    localparam port_bytes_t FORCED_PUSH_PULL = {8'h8c, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
    localparam port_bytes_t TRUE_OPEN_DRAIN = {8'h73, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int PULLUP_PIN = 5;

    // axi answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        KIND_DATA = 3'h1,
        KIND_DIRECTION = 3'h2,
        KIND_OPTION = 3'h4
    } reg_kind_t;

    typedef struct packed {
        logic hit;
        logic [2:0] port;
        reg_kind_t kind;
    } reg_sel_t;

    function automatic reg_sel_t decode_index(input logic [5:0] idx);
        reg_sel_t sel;
        sel = '{hit: 1'b1, port: 3'h0, kind: KIND_DATA};
        unique case (idx)
            IDX_PORT_A_DATA: sel = '{1'b1, 3'h0, KIND_DATA};
            IDX_PORT_A_DIRECTION: sel = '{1'b1, 3'h0, KIND_DIRECTION};
            IDX_PORT_A_OPTION: sel = '{1'b1, 3'h0, KIND_OPTION};
            IDX_PORT_B_DATA: sel = '{1'b1, 3'h1, KIND_DATA};
            IDX_PORT_B_DIRECTION: sel = '{1'b1, 3'h1, KIND_DIRECTION};
            IDX_PORT_C_DATA: sel = '{1'b1, 3'h2, KIND_DATA};
            IDX_PORT_C_DIRECTION: sel = '{1'b1, 3'h2, KIND_DIRECTION};
            IDX_PORT_C_OPTION: sel = '{1'b1, 3'h2, KIND_OPTION};
            IDX_PORT_D_DATA: sel = '{1'b1, 3'h3, KIND_DATA};
            IDX_PORT_D_DIRECTION: sel = '{1'b1, 3'h3, KIND_DIRECTION};
            IDX_PORT_D_OPTION: sel = '{1'b1, 3'h3, KIND_OPTION};
            IDX_PORT_E_DATA: sel = '{1'b1, 3'h4, KIND_DATA};
            IDX_PORT_E_DIRECTION: sel = '{1'b1, 3'h4, KIND_DIRECTION};
            IDX_PORT_E_OPTION: sel = '{1'b1, 3'h4, KIND_OPTION};
            IDX_PORT_F_DATA: sel = '{1'b1, 3'h5, KIND_DATA};
            IDX_PORT_F_DIRECTION: sel = '{1'b1, 3'h5, KIND_DIRECTION};
            default: sel = '{1'b0, 3'h0, KIND_DATA};
        endcase
        return sel;
    endfunction

endpackage

//--- src/parallel_io_port_bank.sv
// six 8-bit general purpose i/o ports with axi4-lite register access
// assumes pins and peripheral requests arrive unsynchronised; one clock
//
// The AXI4-Lite register port is this design's own decision.

// Notes on behaviour
// - input pin with peripheral output: data read returns peripheral output value.
// - output pin with peripheral input: peripheral receives the data latch value.
// - port B: direction 0 floating input, 1 push-pull output.
// - ports A, C, D input: option 0 plain, option 1 with interrupt.
// - ports A, D, E output: option 0 open drain, option 1 push-pull; port C output is always push-pull.
// - port E inputs never interrupt; option only picks output type.
// - pin E5 adds pull-up in floating input and open drain when strapped.
// - data latch writes land whenever WSTRB bit 0 is set, even while the pin is an input.
// - data reads return sampled pin level for input pins.
// - direction bit 0 selects input, 1 selects output.
// - ports without option: direction alone sets fixed pin type.
// - all data, direction and option registers reset to zero.
// - bit n of each register belongs to pin n of its port.
// - output drives latch: push-pull both levels, open drain low only.
// - enabled interrupt pins of a port are combined; any low masks others.
// - peripheral claim overrides port setup; peripheral outputs force output mode.
module parallel_io_port_bank
    import gpio_bank_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // axi4-lite write
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // axi4-lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // pads
    input wire port_bytes_t PIN_IN,
    output port_bytes_t PIN_OUT,
    output port_bytes_t PIN_OE,
    output logic PULLUP_E5_EN,
    input wire logic PULLUP_E5_STRAP,
    // peripheral alternate functions
    input wire port_bytes_t ALT_OUT_EN,
    input wire port_bytes_t ALT_OUT_VAL,
    input wire port_bytes_t ALT_OUT_OPEN_DRAIN,
    output port_bytes_t ALT_IN,
    // combined external interrupt lines, low requests
    output port_flags_t EXT_IRQ_LINE_N
);

    // register file
    port_bytes_t pin_data_latch_ff;
    port_bytes_t direction_field_ff;
    port_bytes_t option_ff;

    // synchronisers
    port_bytes_t pin_meta_ff, pin_sync_ff;
    port_bytes_t alt_en_meta_ff, alt_en_ff;
    port_bytes_t alt_val_meta_ff, alt_val_ff;
    port_bytes_t alt_od_meta_ff, alt_od_ff;
    logic strap_meta_ff, strap_ff;

    // bus state
    logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [PORT_W-1:0] wdata_ff;
    logic wstrb0_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid, do_write;
    reg_sel_t wsel, rsel;

    // pad state
    port_bytes_t pin_out_ff, pin_oe_ff, alt_in_ff;
    port_flags_t irq_line_n_ff;
    logic pullup_ff;
    port_bytes_t nxt_pin_out, nxt_pin_oe, nxt_alt_in, eff_od, read_val;
    port_flags_t nxt_irq_line_n;

    // two-flop synchronisers for pins, peripheral requests and the pull-up strap
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            alt_en_meta_ff <= '0;
            alt_en_ff <= '0;
            alt_val_meta_ff <= '0;
            alt_val_ff <= '0;
            alt_od_meta_ff <= '0;
            alt_od_ff <= '0;
            strap_meta_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else begin
            pin_meta_ff <= PIN_IN;
            pin_sync_ff <= pin_meta_ff;
            alt_en_meta_ff <= ALT_OUT_EN;
            alt_en_ff <= alt_en_meta_ff;
            alt_val_meta_ff <= ALT_OUT_VAL;
            alt_val_ff <= alt_val_meta_ff;
            alt_od_meta_ff <= ALT_OUT_OPEN_DRAIN;
            alt_od_ff <= alt_od_meta_ff;
            strap_meta_ff <= PULLUP_E5_STRAP;
            strap_ff <= strap_meta_ff;
        end
    end

    // write channel: address and data taken in either order
    always_comb begin
        do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
        nxt_aw_held = (aw_held_ff | (AWVALID & awready_ff)) & ~do_write;
        nxt_w_held = (w_held_ff | (WVALID & wready_ff)) & ~do_write;
        nxt_bvalid = do_write | (bvalid_ff & ~BREADY);
        wsel = decode_index(waddr_ff[7:2]);
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb0_ff <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (AWVALID && awready_ff) begin
                waddr_ff <= AWADDR;
            end
            if (WVALID && wready_ff) begin
                wdata_ff <= WDATA[PORT_W-1:0];
                wstrb0_ff <= WSTRB[0];
            end
            if (do_write) begin
                bresp_ff <= wsel.hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // register writes; latch written whatever the direction
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_data_latch_ff <= {NUM_PORTS{RESET_DATA}};
            direction_field_ff <= {NUM_PORTS{RESET_DIRECTION}};
            option_ff <= {NUM_PORTS{RESET_OPTION}};
        end else if (do_write && wsel.hit && wstrb0_ff) begin
            unique case (wsel.kind)
                KIND_DATA: pin_data_latch_ff[wsel.port] <= wdata_ff;
                KIND_DIRECTION: direction_field_ff[wsel.port] <= wdata_ff;
                KIND_OPTION: option_ff[wsel.port] <= wdata_ff;
            endcase
        end
    end

    // read channel
    always_comb begin
        nxt_rvalid = (ARVALID & arready_ff) | (rvalid_ff & ~RREADY);
        rsel = decode_index(ARADDR[7:2]);
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ARVALID && arready_ff) begin
                rresp_ff <= rsel.hit ? RESP_OKAY : RESP_SLVERR;
                rdata_ff <= '0;
                if (rsel.hit) begin
                    unique case (rsel.kind)
                        KIND_DATA: rdata_ff[PORT_W-1:0] <= read_val[rsel.port];
                        KIND_DIRECTION: rdata_ff[PORT_W-1:0] <= direction_field_ff[rsel.port];
                        KIND_OPTION: rdata_ff[PORT_W-1:0] <= option_ff[rsel.port];
                    endcase
                end
            end
        end
    end

    // per-port pad, peripheral and interrupt logic; bit n is pin n
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [PORT_W-1:0] opt, dir, val, irq_en;
            always_comb begin
                opt = HAS_OPTION_PORTS[p] ? option_ff[p] : 8'h00;
                // peripheral outputs force output mode
                dir = direction_field_ff[p] | alt_en_ff[p];
                val = (alt_en_ff[p] & alt_val_ff[p]) | (~alt_en_ff[p] & pin_data_latch_ff[p]);
                // open drain: option 0 unless fixed push-pull, or true open drain
                eff_od[p] = (alt_en_ff[p] & alt_od_ff[p])
                    | (~alt_en_ff[p] & (TRUE_OPEN_DRAIN[p]
                    | (~FORCED_PUSH_PULL[p] & ~opt)));
                nxt_pin_oe[p] = dir & (~val | ~eff_od[p]);
                nxt_pin_out[p] = val & ~eff_od[p] & dir;
                // input with peripheral output reads that output
                read_val[p] = (alt_en_ff[p] & ~direction_field_ff[p] & alt_val_ff[p])
                    | (~(alt_en_ff[p] & ~direction_field_ff[p]) & pin_sync_ff[p]);
                // peripheral input on an output pin sees the latch
                nxt_alt_in[p] = (direction_field_ff[p] & pin_data_latch_ff[p])
                    | (~direction_field_ff[p] & pin_sync_ff[p]);
                // interrupt only on capable ports, input mode, option 1
                irq_en = IRQ_PORTS[p] ? (opt & ~dir) : 8'h00;
                nxt_irq_line_n[p] = &(pin_sync_ff[p] | ~irq_en);
            end
        end
    endgenerate

    // registered pad and peripheral outputs
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            alt_in_ff <= '0;
            irq_line_n_ff <= '1;
            pullup_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            alt_in_ff <= nxt_alt_in;
            irq_line_n_ff <= nxt_irq_line_n;
            // pull-up when direction bit is 0 or the pin is open drain
            pullup_ff <= strap_ff & ~(direction_field_ff[PORT_E][PULLUP_PIN]
                & ~eff_od[PORT_E][PULLUP_PIN]);
        end
    end

    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;
    assign PIN_OUT = pin_out_ff;
    assign PIN_OE = pin_oe_ff;
    assign ALT_IN = alt_in_ff;
    assign EXT_IRQ_LINE_N = irq_line_n_ff;
    assign PULLUP_E5_EN = pullup_ff;

    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_read_port_a_data;
        ARVALID && arready_ff && ARADDR[7:2] == IDX_PORT_A_DATA;
    endsequence

    sequence s_read_port_d_data;
        ARVALID && arready_ff && ARADDR[7:2] == IDX_PORT_D_DATA;
    endsequence

    sequence s_write_taken;
        do_write && wsel.hit && wstrb0_ff && wsel.kind == KIND_DATA;
    endsequence

    property p_read_alt;
        logic [7:0] m, v;
        (s_read_port_d_data, m = alt_en_ff[PORT_D] & ~direction_field_ff[PORT_D],
            v = alt_val_ff[PORT_D])
            |=> ((RDATA[7:0] & m) == (v & m)) && RVALID;
    endproperty
    a_read_alt: assert property (p_read_alt)
        else $error("alt output not read back");

    property p_alt_in_latch;
        direction_field_ff[PORT_D] == 8'hff |=> ALT_IN[PORT_D] == $past(pin_data_latch_ff[PORT_D]);
    endproperty
    a_alt_in_latch: assert property (p_alt_in_latch)
        else $error("peripheral did not see latch");

    property p_port_b_dir;
        alt_en_ff[PORT_B] == 8'h00 |=> PIN_OE[PORT_B] == $past(direction_field_ff[PORT_B])
            && PIN_OUT[PORT_B] == ($past(pin_data_latch_ff[PORT_B]) & PIN_OE[PORT_B]);
    endproperty
    a_port_b_dir: assert property (p_port_b_dir)
        else $error("port b pin type wrong");

    property p_irq_mask;
        (option_ff[PORT_A][0] && !direction_field_ff[PORT_A][0] && !alt_en_ff[PORT_A][0]
            && !pin_sync_ff[PORT_A][0]) |=> !EXT_IRQ_LINE_N[PORT_A];
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("low pin did not pull request");

    property p_no_irq_e;
        EXT_IRQ_LINE_N[PORT_E] && EXT_IRQ_LINE_N[PORT_B] && EXT_IRQ_LINE_N[PORT_F];
    endproperty
    a_no_irq_e: assert property (p_no_irq_e)
        else $error("port without interrupt requested");

    property p_open_drain_a;
        logic [7:0] m;
        (1'b1, m = direction_field_ff[PORT_A] & ~option_ff[PORT_A] & ~alt_en_ff[PORT_A]
            & pin_data_latch_ff[PORT_A]) |=> (PIN_OE[PORT_A] & m) == 8'h00;
    endproperty
    a_open_drain_a: assert property (p_open_drain_a)
        else $error("open drain drove high");

    property p_latch_write;
        logic [2:0] pt;
        logic [7:0] d;
        (s_write_taken, pt = wsel.port, d = wdata_ff) ##1 1'b1 |-> pin_data_latch_ff[pt] == d;
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch write lost");

    property p_true_od_f;
        (PIN_OUT[PORT_F] & TRUE_OPEN_DRAIN[PORT_F] & ~$past(alt_en_ff[PORT_F])) == 8'h00;
    endproperty
    a_true_od_f: assert property (p_true_od_f)
        else $error("true open drain drove high");

    property p_port_c_pp;
        alt_en_ff[PORT_C] == 8'h00 |=> PIN_OE[PORT_C] == $past(direction_field_ff[PORT_C]);
    endproperty
    a_port_c_pp: assert property (p_port_c_pp)
        else $error("port c not push-pull");

    property p_pullup_pp;
        direction_field_ff[PORT_E][PULLUP_PIN] && option_ff[PORT_E][PULLUP_PIN]
            && !alt_en_ff[PORT_E][PULLUP_PIN] |=> !PULLUP_E5_EN;
    endproperty
    a_pullup_pp: assert property (p_pullup_pp)
        else $error("pull-up on push-pull pin");

    property p_reset_clear;
        $rose(RESET_N) |-> pin_data_latch_ff == '0 && direction_field_ff == '0
            && option_ff == '0 && !AWREADY && !BVALID && !RVALID;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("registers not clear after reset");

    property p_input_floats;
        port_bytes_t m;
        (1'b1, m = ~direction_field_ff & ~alt_en_ff) |=> (PIN_OE & m) == '0;
    endproperty
    a_input_floats: assert property (p_input_floats)
        else $error("input pin driven");

    property p_read_pin;
        logic [7:0] m, v;
        (s_read_port_a_data, m = ~direction_field_ff[PORT_A] & ~alt_en_ff[PORT_A],
            v = pin_sync_ff[PORT_A]) |=> (RDATA[7:0] & m) == (v & m);
    endproperty
    a_read_pin: assert property (p_read_pin)
        else $error("input pin level not read");

    property p_alt_drives;
        port_bytes_t m;
        (1'b1, m = alt_en_ff & ~(alt_od_ff & alt_val_ff)) |=> (PIN_OE & m) == m;
    endproperty
    a_alt_drives: assert property (p_alt_drives)
        else $error("peripheral output not driven");

    property p_one_write;
        BVALID |-> !AWREADY && !WREADY;
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("write accepted with response pending");

endmodule

//--- test/pin_world_model.sv
// pad model: external circuitry around the port bank pins
// assumes pad outputs come from the bank and the bench sets the outside drivers
module pin_world_model
    import gpio_bank_pkg::*;
(
    // clock
    input wire logic clk,
    // bank side
    input wire port_bytes_t pin_out,
    input wire port_bytes_t pin_oe,
    input wire logic pullup_e5_en,
    // bench side
    input wire port_bytes_t ext_en,
    input wire port_bytes_t ext_val,
    output port_bytes_t pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wobble_ff = 1'b0;
    always @(posedge clk) begin
        wobble_ff <= ~wobble_ff;
    end
    // undriven pads wobble unless the E5 pull-up is on, so no stale level can be read back
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                if (pin_oe[p][b])
                    pin_in[p][b] = pin_out[p][b];
                else if (ext_en[p][b])
                    pin_in[p][b] = ext_val[p][b];
                else if (p == PORT_E && b == PULLUP_PIN && pullup_e5_en)
                    pin_in[p][b] = 1'b1;
                else
                    pin_in[p][b] = wobble_ff ^ b[0];
            end
        end
    end
endmodule

//--- test/tb_parallel_io_port_bank.sv
// bench for the six-port i/o bank: register table, reset, pad and peripheral cases
// assumes the package and the pad model are compiled first
module tb_parallel_io_port_bank
    import gpio_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0] idx; logic [7:0] wd; logic [3:0] st; logic [7:0] ex; logic [1:0] rs;
    } row_t;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, strap;
    logic awready, wready, bvalid, arready, rvalid, pu_en;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    port_bytes_t pin_in, pin_out, pin_oe, alt_en, alt_val, alt_od, alt_in, ext_en, ext_val;
    port_flags_t irq_n;
    int mismatches = 0;
    int n_checks = 0;
    row_t rows [14] = '{'{6'h01, 8'ha5, 4'hf, 8'ha5, 2'h0}, '{6'h02, 8'h5a, 4'hf, 8'h5a, 2'h0},
        '{6'h04, 8'h3c, 4'hf, 8'h3c, 2'h0}, '{6'h07, 8'hc3, 4'hf, 8'hc3, 2'h0},
        '{6'h08, 8'h69, 4'hf, 8'h69, 2'h0}, '{6'h0a, 8'h96, 4'hf, 8'h96, 2'h0},
        '{6'h0b, 8'h0f, 4'hf, 8'h0f, 2'h0}, '{6'h0d, 8'hf0, 4'hf, 8'hf0, 2'h0},
        '{6'h0e, 8'h11, 4'hf, 8'h11, 2'h0}, '{6'h10, 8'h88, 4'hf, 8'h88, 2'h0},
        '{6'h10, 8'h77, 4'he, 8'h88, 2'h0}, '{6'h05, 8'hff, 4'hf, 8'h00, 2'h2},
        '{6'h11, 8'hff, 4'hf, 8'h00, 2'h2}, '{6'h3f, 8'hff, 4'hf, 8'h00, 2'h2}};

    parallel_io_port_bank parallel_io_port_bank_inst (
        .SYS_CLK(clk), .RESET_N(rst_n),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PULLUP_E5_EN(pu_en), .PULLUP_E5_STRAP(strap),
        .ALT_OUT_EN(alt_en), .ALT_OUT_VAL(alt_val), .ALT_OUT_OPEN_DRAIN(alt_od),
        .ALT_IN(alt_in), .EXT_IRQ_LINE_N(irq_n)
    );
    pin_world_model pin_world_model_inst (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_e5_en(pu_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= {a, 2'b00};
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= {a, 2'b00};
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        got = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [7:0] e);
        rd(a);
        chk(48'(got), 48'(e));
    endtask

    task automatic st;
        repeat (6) @(posedge clk);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, strap} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {alt_en, alt_val, alt_od, ext_val} = '0;
        ext_en = '1;
        do_reset();
        @(posedge clk);
        chk(pin_oe, 48'h0);
        chk(48'({irq_n, pu_en}), 48'h7e);
        done("reset");
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd, rows[i].st);
            chk(48'(rsp), 48'(rows[i].rs));
            rd(rows[i].idx);
            chk(48'(got), 48'(rows[i].ex));
            chk(48'(rsp), 48'(rows[i].rs));
        end
        done("register_table");
        do_reset();
        for (int i = 0; i <= 16; i++) if (i != 5) rc(6'(i), 8'h00);
        done("mid_run_reset");
        ext_val[0] <= 8'hff;
        wr(6'h02, 8'h03);
        st();
        chk(48'(irq_n), 48'h3f);
        ext_val[0] <= 8'hfe;
        st();
        chk(48'(irq_n), 48'h3e);
        ext_val[0] <= 8'h7f;
        st();
        chk(48'(irq_n), 48'h3f);
        wr(6'h02, 8'h00);
        ext_val[0] <= 8'hfc;
        st();
        chk(48'(irq_n), 48'h3f);
        done("interrupt_combine");
        ext_en[3] <= 8'hfd;
        alt_en[3] <= 8'h02;
        alt_val[3] <= 8'h02;
        st();
        rc(6'h09, 8'h02);
        chk(48'({pin_oe[3], pin_out[3] & 8'h02}), 48'h0202);
        alt_od[3] <= 8'h02;
        ext_en[3] <= 8'hff;
        st();
        rc(6'h09, 8'h02);
        alt_en[3] <= 8'h00;
        alt_od[3] <= 8'h00;
        done("alternate_output");
        ext_val[0] <= 8'ha5;
        wr(6'h00, 8'h3c);
        st();
        rc(6'h00, 8'ha5);
        ext_en[0] <= 8'h00;
        wr(6'h01, 8'hff);
        wr(6'h02, 8'hff);
        st();
        chk(48'({pin_oe[0], pin_out[0]}), 48'hff3c);
        rc(6'h00, 8'h3c);
        done("latch_and_pin");
        ext_en[3] <= 8'h00;
        wr(6'h09, 8'h0f);
        wr(6'h0a, 8'hff);
        st();
        chk(48'({pin_oe[3], pin_out[3] & pin_oe[3]}), 48'hf000);
        chk(48'(alt_in[3]), 48'h0f);
        wr(6'h0b, 8'hff);
        st();
        chk(48'({pin_oe[3], pin_out[3]}), 48'hff0f);
        done("open_drain");
        ext_en <= '0;
        wr(6'h03, 8'h5a);
        wr(6'h04, 8'hff);
        wr(6'h06, 8'hff);
        wr(6'h07, 8'hff);
        wr(6'h0f, 8'hff);
        wr(6'h10, 8'hff);
        st();
        chk(48'({pin_oe[1], pin_out[1]}), 48'hff5a);
        chk(48'({pin_oe[2], pin_out[2]}), 48'hffff);
        chk(48'({pin_oe[5], pin_out[5] & 8'h8c}), 48'h8c8c);
        wr(6'h0f, 8'h00);
        st();
        chk(48'(pin_oe[5]), 48'hff);
        done("fixed_types");
        ext_en[4] <= 8'hdf;
        strap <= 1'b1;
        wr(6'h0e, 8'hff);
        st();
        chk(48'({irq_n[4], pu_en}), 48'h3);
        rc(6'h0c, 8'h20);
        wr(6'h0d, 8'h20);
        st();
        chk(48'(pu_en), 48'h0);
        wr(6'h0e, 8'h00);
        st();
        chk(48'(pu_en), 48'h1);
        strap <= 1'b0;
        st();
        chk(48'(pu_en), 48'h0);
        done("port_e_pullup");
        report_and_stop();
    end
endmodule
